// File: rtl/irq_ctrl.sv
/*
 * two-level prioritised interrupt controller with AXI4-Lite registers.
 * assumes the core pulses retIrq when it executes the return instruction,
 * accepts pcLoad/stackPush pulses, and that source events are one-clock
 * pulses synchronous to clk.
 */
// The register offsets and the AXI4-Lite register port were left to the implementer.
// Functional notes
// R1 - priority mode: high requests vector to 0008h, low requests to 0018h
// R2 - enabled high request pre-empts a low-level service already running
// R3 - every source has a flag, an enable and a priority bit
// R4 - priority scheme active only while priority-enable bit 7 of reset control is set
// R5 - priority mode: bit 7 of control A enables all high-priority sources
// R6 - priority mode: bit 6 of control A enables all low-priority sources
// R7 - flag, enable and matching global enable set vectors by priority bit
// R8 - priority-enable resets to zero, starting in compatibility mode
// R9 - compatibility mode ignores all priority bits
// R10 - compatibility mode: bit 6 of control A gates peripheral sources
// R11 - compatibility mode: bit 7 of control A gates all sources
// R12 - compatibility mode: every accepted interrupt vectors to 0008h
// R13 - on acceptance clear the single, high or low global enable
// R14 - no low request accepted while high service is active
// R15 - on entry push return address and load the vector into pc
// R16 - software clears the serviced flag before re-enabling interrupts
// R17 - return instruction sets again the global enable cleared at entry
// R18 - latency fixed, three to four cycles, independent of instruction length
// R19 - flags set on events regardless of any enable
// R20 - software should clear a flag before enabling its source
// R21 - software avoids memory-to-memory moves on control registers when enabled
// R22 - priority mode: low enable gates low sources; clearing high enable stops all
// R23 - separate high and low request outputs from flag and enable per priority
// R24 - any set and enabled flag raises wake-up while core sleeps or idles
`timescale 1ns/1ps
module irq_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite slave
   input wire logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [irq_ctrl_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // sources and core
   input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] srcEvent,
   input wire logic [irq_ctrl_pkg::PC_W-1:0] returnAddr,
   input wire logic retIrq,
   input wire logic coreSleep,
   output logic irqHigh,
   output logic irqLow,
   output logic wakeUp,
   output logic pcLoad,
   output logic stackPush,
   output logic [irq_ctrl_pkg::PC_W-1:0] pcVector,
   output logic [irq_ctrl_pkg::PC_W-1:0] stackData
);
   import irq_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic prioEn_r;
   logic gieHigh_r, gieHigh_nxt;
   logic gieLow_r, gieLow_nxt;
   logic [NUM_SRC-1:0] flags_r, flags_nxt;
   logic [NUM_SRC-1:0] enables_r, enables_nxt;
   logic [NUM_SRC-1:0] prios_r, prios_nxt;
   logic svcHigh_r, svcLow_r;
   logic selHigh_r;
   logic [1:0] waitCnt_r;
   logic [PC_W-1:0] vector_r, retAddr_r;
   ctrl_state_t state_r, state_nxt;
   logic awHeld_r, wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // bus write path: address and data taken in either order
   wire doWrite = awHeld_r & wHeld_r & ~bvalid_r;
   wire selRst = doWrite & (awAddr_r == OFS_RESET_CTRL);
   wire selCtlA = doWrite & (awAddr_r == OFS_IRQ_CTRL_A);
   wire selFlags = doWrite & (awAddr_r == OFS_FLAGS);
   wire selEn = doWrite & (awAddr_r == OFS_ENABLES);
   wire selPrio = doWrite & (awAddr_r == OFS_PRIORITIES);
   wire wrMapped = selRst | selCtlA | selFlags | selEn | selPrio
                   | (awAddr_r == OFS_STATUS);
   wire [NUM_SRC-1:0] laneMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   wire [NUM_SRC-1:0] wrBits = wData_r[NUM_SRC-1:0];

   assign awready = ~awHeld_r & ~bvalid_r;
   assign wready = ~wHeld_r & ~bvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   // write channel holding registers and response
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid & wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-source qualification, one instance per source
   logic [NUM_SRC-1:0] flagEn, srcHigh, srcLow, srcCompat;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
         localparam bit IS_PERIPH = (gi >= NUM_CORE_SRC);
         assign flagEn[gi] = flags_r[gi] & enables_r[gi];                // [R3]
         assign srcHigh[gi] = flagEn[gi] & (prios_r[gi] | ~prioEn_r);    // [R9] [R23]
         assign srcLow[gi] = flagEn[gi] & ~prios_r[gi] & prioEn_r;       // [R23]
         assign srcCompat[gi] = flagEn[gi] & (~IS_PERIPH | gieLow_r);    // [R10]
      end
   endgenerate

   // request outputs and wake-up
   assign irqHigh = |srcHigh;                       // [R23]
   assign irqLow = |srcLow;                         // [R23]
   assign wakeUp = coreSleep & (|flagEn);           // [R24]

   // acceptance conditions per mode
   wire acceptHigh = prioEn_r & gieHigh_r & irqHigh;                       // [R5] [R2]
   wire acceptLow = prioEn_r & gieHigh_r & gieLow_r & irqLow & ~svcHigh_r  // [R6] [R22]
                    & ~acceptHigh;                                          // [R14]
   wire acceptCompat = ~prioEn_r & gieHigh_r & (|srcCompat);               // [R11]
   wire accept = (state_r == ST_IDLE) & (acceptHigh | acceptLow | acceptCompat); // [R7]
   wire pickHigh = acceptHigh | acceptCompat;
   wire [PC_W-1:0] pickVector = (acceptLow & ~acceptHigh) ? VEC_LOW : VEC_HIGH; // [R1] [R12]

   ////////////////////////////////////////////////////////////////////////////
   // entry sequencer: fixed latency, independent of the running instruction
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (waitCnt_r == WAIT_LAST) begin               // [R18]
               state_nxt = ST_ENTER;
            end
         end
         ST_ENTER: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   wire entering = (state_r == ST_ENTER);
   assign pcLoad = entering;                         // [R15]
   assign stackPush = entering;                      // [R15]
   assign pcVector = vector_r;
   assign stackData = retAddr_r;

   // sequencer registers and service levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         waitCnt_r <= '0;
         selHigh_r <= 1'b0;
         vector_r <= VEC_HIGH;
         retAddr_r <= '0;
         svcHigh_r <= 1'b0;
         svcLow_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         waitCnt_r <= (state_r == ST_WAIT) ? waitCnt_r + 2'h1 : 2'h0;
         if (accept) begin
            selHigh_r <= pickHigh;
            vector_r <= pickVector;                  // [R7]
            retAddr_r <= returnAddr;
         end
         if (entering & selHigh_r) begin
            svcHigh_r <= 1'b1;
         end else if (retIrq & svcHigh_r) begin
            svcHigh_r <= 1'b0;
         end
         if (entering & ~selHigh_r) begin
            svcLow_r <= 1'b1;
         end else if (retIrq & ~svcHigh_r & svcLow_r) begin
            svcLow_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // global enables: software write, then return sets, then entry clears
   wire retHigh = retIrq & svcHigh_r;
   wire retLow = retIrq & ~svcHigh_r & svcLow_r;
   always_comb begin
      gieHigh_nxt = (selCtlA & wStrb_r[0]) ? wData_r[BIT_GIE_HIGH] : gieHigh_r;
      gieLow_nxt = (selCtlA & wStrb_r[0]) ? wData_r[BIT_GIE_LOW] : gieLow_r;
      if (retHigh) begin
         gieHigh_nxt = 1'b1;                         // [R17]
      end
      if (retLow) begin
         gieLow_nxt = 1'b1;                          // [R17]
      end
      if (entering & selHigh_r) begin
         gieHigh_nxt = 1'b0;                         // [R13]
      end
      if (entering & ~selHigh_r) begin
         gieLow_nxt = 1'b0;                          // [R13]
      end
   end

   // source bits: events set flags and win over a software clear
   assign flags_nxt = (selFlags ? ((flags_r & ~laneMask) | (wrBits & laneMask)) : flags_r)
                      | srcEvent;                    // [R19]
   assign enables_nxt = selEn ? ((enables_r & ~laneMask) | (wrBits & laneMask)) : enables_r;
   assign prios_nxt = selPrio ? ((prios_r & ~laneMask) | (wrBits & laneMask)) : prios_r;

   // control and source registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prioEn_r <= RST_PRIO_EN;                    // [R8]
         gieHigh_r <= RST_GIE[1];
         gieLow_r <= RST_GIE[0];
         flags_r <= RST_FLAGS;
         enables_r <= RST_ENABLES;
         prios_r <= RST_PRIORITIES;
      end else begin
         if (selRst & wStrb_r[0]) begin
            prioEn_r <= wData_r[BIT_PRIO_EN];        // [R4]
         end
         gieHigh_r <= gieHigh_nxt;
         gieLow_r <= gieLow_nxt;
         flags_r <= flags_nxt;
         enables_r <= enables_nxt;
         prios_r <= prios_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus read path: answer one cycle after the address is taken
   wire [31:0] rdCtrl = 32'(prioEn_r) << BIT_PRIO_EN;
   wire [31:0] rdCtlA = (32'(gieHigh_r) << BIT_GIE_HIGH) | (32'(gieLow_r) << BIT_GIE_LOW);
   wire [31:0] rdStatus = (32'(svcHigh_r) << BIT_ST_SVC_HIGH)
                          | (32'(svcLow_r) << BIT_ST_SVC_LOW)
                          | (32'(state_r) << BIT_ST_STATE)
                          | (32'(vector_r) << BIT_ST_VECTOR);
   wire rdHit = (araddr == OFS_RESET_CTRL) | (araddr == OFS_IRQ_CTRL_A)
                | (araddr == OFS_FLAGS) | (araddr == OFS_ENABLES)
                | (araddr == OFS_PRIORITIES) | (araddr == OFS_STATUS);
   wire [31:0] rdMux =
      (araddr == OFS_RESET_CTRL) ? rdCtrl :
      (araddr == OFS_IRQ_CTRL_A) ? rdCtlA :
      (araddr == OFS_FLAGS) ? 32'(flags_r) :
      (araddr == OFS_ENABLES) ? 32'(enables_r) :
      (araddr == OFS_PRIORITIES) ? 32'(prios_r) :
      (araddr == OFS_STATUS) ? rdStatus : 32'h0000_0000;

   assign arready = ~rvalid_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // read response registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (arvalid & arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rdMux;
         rresp_r <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_accept_high;
      accept & acceptHigh;
   endsequence
   sequence s_accept_low;
      accept & acceptLow;
   endsequence
   sequence s_enter_at_latency;
      ##IRQ_LATENCY_CYC pcLoad & stackPush;
   endsequence

   high_vector_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
      s_accept_high |-> s_enter_at_latency ##0 (pcVector == VEC_HIGH))
      else $error("high request did not vector to the high address");
   low_vector_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
      s_accept_low |-> s_enter_at_latency ##0 (pcVector == VEC_LOW))
      else $error("low request did not vector to the low address");
   compat_vector_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
      (pcLoad & ~prioEn_r) |-> (pcVector == VEC_HIGH))
      else $error("compatibility entry used a vector other than the high one");
   entry_latency_a: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
      accept |=> (~pcLoad)[*2] ##1 pcLoad ##1 ~pcLoad)
      else $error("entry latency differs from the fixed count");
   gie_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
      (pcLoad & selHigh_r) |=> ~gieHigh_r)
      else $error("global enable not cleared on entry");
   no_low_in_high_a: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
      (pcLoad & svcHigh_r) |-> (pcVector == VEC_HIGH))
      else $error("low request entered during high service");
   ret_restore_a: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
      (retIrq & svcHigh_r & ~pcLoad) |=> gieHigh_r & ~svcHigh_r)
      else $error("return did not restore the high global enable");
   flag_set_a: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
      srcEvent[0] |=> flags_r[0])
      else $error("event did not set its flag");
   prio_reset_a: assert property (@(posedge clk) // [R8]
      sys_rst |=> ~prioEn_r)
      else $error("priority enable not clear after reset");
   wake_a: assert property (@(posedge clk) disable iff (sys_rst) // [R24]
      (coreSleep & flags_r[0] & enables_r[0]) |-> wakeUp)
      else $error("wake-up missing for an enabled pending flag");
   gie_clear_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
      (pcLoad & ~selHigh_r) |=> ~gieLow_r)
      else $error("low global enable not cleared on entry");
   ret_restore_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
      (retIrq & ~svcHigh_r & svcLow_r & ~pcLoad) |=> gieLow_r & ~svcLow_r)
      else $error("return did not restore the low global enable");
   push_addr_a: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
      accept |-> ##3 (stackData == $past(returnAddr, 3)))
      else $error("pushed address is not the one seen at acceptance");
   stop_all_a: assert property (@(posedge clk) disable iff (sys_rst) // [R22] [R11]
      ((state_r == ST_IDLE) & ~gieHigh_r) |-> ##3 ~pcLoad)
      else $error("entry taken with the high global enable clear");
endmodule : irq_ctrl

// File: rtl/irq_ctrl_pkg.sv
/*
 * constants for the two-level priority interrupt controller: register
 * offsets, field positions, reset values, vectors, timing and state codes.
 * assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
 */
package irq_ctrl_pkg;
   // source counts: low sources are core sources, the rest are peripherals
   localparam int NUM_SRC = 16;
   localparam int NUM_CORE_SRC = 8;
   localparam int ADDR_W = 8;
   localparam int PC_W = 16;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL_A = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ENABLES = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PRIORITIES = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

   // field positions
   localparam int BIT_PRIO_EN = 7;
   localparam int BIT_GIE_HIGH = 7;
   localparam int BIT_GIE_LOW = 6;
   localparam int BIT_ST_SVC_HIGH = 0;
   localparam int BIT_ST_SVC_LOW = 1;
   localparam int BIT_ST_STATE = 2;
   localparam int BIT_ST_VECTOR = 16;

   // reset values
   localparam logic RST_PRIO_EN = 1'b0;
   localparam logic [1:0] RST_GIE = 2'h0;
   localparam logic [NUM_SRC-1:0] RST_FLAGS = 16'h0000;
   localparam logic [NUM_SRC-1:0] RST_ENABLES = 16'h0000;
   localparam logic [NUM_SRC-1:0] RST_PRIORITIES = 16'hFFFF;

   // vector addresses
   localparam logic [PC_W-1:0] VEC_HIGH = 16'h0008;
   localparam logic [PC_W-1:0] VEC_LOW = 16'h0018;

   // request-to-entry latency in instruction cycles (one clk each)
   localparam int IRQ_LATENCY_CYC = 3;
   localparam logic [1:0] WAIT_LAST = 2'(IRQ_LATENCY_CYC - 2);

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // controller states, gray along idle -> wait -> enter; both bits change on enter -> idle
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_ENTER = 2'h3
   } ctrl_state_t;
endpackage : irq_ctrl_pkg

// File: testbench/core_model.sv
/*
 * behavioural stand-in for the processor core facing the interrupt controller.
 * assumes pcLoad and stackPush arrive as one-clock pulses at interrupt entry.
 */
`timescale 1ns/1ps
module core_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pcLoad,
   input wire logic stackPush,
   input wire logic retReq,
   output logic [irq_ctrl_pkg::PC_W-1:0] returnAddr,
   output logic retIrq,
   output int entries
);
   import irq_ctrl_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////////////
   // return address moves every cycle so a late or early capture shows up
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         returnAddr <= 16'h0100;
         retIrq <= 1'b0;
         entries <= 0;
      end else begin
         returnAddr <= returnAddr + 16'h0101;
         retIrq <= retReq; // one-cycle return pulse on command
         if (pcLoad && stackPush) begin
            entries <= entries + 1; // entry only counts when push and load coincide
         end
      end
   end
endmodule : core_model

// File: testbench/test_two_level_priority_interrupt_ctrl.sv
/*
 * self-checking bench: register model, compat and priority entry, nesting, wake-up.
 * assumes irq_ctrl_pkg is compiled first and core_model stands on the core side.
 */
`timescale 1ns/1ps
module test_two_level_priority_interrupt_ctrl;
   import irq_ctrl_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic [NUM_SRC-1:0] srcEvent = 16'h0000;
   logic coreSleep = 1'b0, retReq = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irqHigh, irqLow;
   logic wakeUp, pcLoad, stackPush, retIrq;
   logic [1:0] bresp, rresp, r;
   logic [PC_W-1:0] returnAddr, pcVector, stackData;
   int entries, cnt, n_mismatch = 0, n_compared = 0;
   int m[5] = '{0, 0, 0, 0, 32'hFFFF};
   int mask[5] = '{32'h80, 32'hC0, 32'hFFFF, 32'hFFFF, 32'hFFFF};
   logic svc[$];
   logic [15:0] rnd = 16'h8046;

   always #2.5 clk = ~clk;

   irq_ctrl irq_ctrl_i (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .srcEvent(srcEvent), .returnAddr(returnAddr), .retIrq(retIrq), .coreSleep(coreSleep),
      .irqHigh(irqHigh), .irqLow(irqLow), .wakeUp(wakeUp), .pcLoad(pcLoad),
      .stackPush(stackPush), .pcVector(pcVector), .stackData(stackData));

   core_model core_model_i (.clk(clk), .sys_rst(sys_rst), .pcLoad(pcLoad),
      .stackPush(stackPush), .retReq(retReq), .returnAddr(returnAddr), .retIrq(retIrq),
      .entries(entries));

   ////////////////////////////////////////////////////////////////////////////////////////
   // verdict and comparison
   task automatic wrap_up();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   ////////////////////////////////////////////////////////////////////////////////////////
   // one register transfer; ready and valid looked at mid-cycle, released after the edge
   task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      bit ta, tw, ta2, tr;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      bready <= wr;
      arvalid <= !wr;
      rready <= !wr;
      for (i = 0; i < 40; i++) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         ta2 = arvalid && arready;
         tr = (bvalid && bready) || (rvalid && rready);
         r = wr ? bresp : rresp;
         q = rdata;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (ta2) arvalid <= 1'b0;
         if (tr) break;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      if (i == 40) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : axi

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi(1'b1, a, d); // whole-word bus writes only, no memory-to-memory move
      chk(32'(r), 32'(a <= OFS_STATUS ? RESP_OKAY : RESP_SLVERR));
      if (a < OFS_STATUS) m[a >> 2] = d & mask[a >> 2];
   endtask : wr

   task automatic rdm(input logic [7:0] a);
      axi(1'b0, a, 32'h0);
      chk(q, a < OFS_STATUS ? m[a >> 2] : 32'h0);
      chk(32'(r), 32'(a < OFS_STATUS ? RESP_OKAY : RESP_SLVERR));
   endtask : rdm

   ////////////////////////////////////////////////////////////////////////////////////////
   // request outputs against the model
   task automatic chk_out();
      int act;
      logic hi, lo;
      act = m[2] & m[3];
      hi = m[0][7] ? (act & m[4]) != 0 : act != 0;
      lo = m[0][7] && (act & ~m[4] & 32'hFFFF) != 0;
      chk({29'h0, irqHigh, irqLow, wakeUp}, {29'h0, hi, lo, coreSleep && act != 0});
   endtask : chk_out

   task automatic pulse(input logic [15:0] v);
      @(posedge clk);
      srcEvent <= v;
      @(posedge clk);
      srcEvent <= 16'h0000;
      m[2] = m[2] | v;
      @(negedge clk);
      chk_out();
   endtask : pulse

   // waits for entry, checks vector and push, clears the used enable in the model
   task automatic entry(input logic lvlLow);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (pcLoad !== 1'b1 && cnt < 30);
      if (pcLoad !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      chk(32'(pcVector), 32'(lvlLow ? VEC_LOW : VEC_HIGH));
      chk({31'h0, stackPush}, 32'h1);
      chk(32'(stackData), 32'(returnAddr - 16'h0303));
      m[1] = m[1] & ~(lvlLow ? 32'h40 : 32'h80);
      svc.push_back(lvlLow);
   endtask : entry

   task automatic ret();
      logic lvl;
      lvl = svc.pop_back();
      @(posedge clk);
      retReq <= 1'b1;
      @(posedge clk);
      retReq <= 1'b0;
      m[1] = m[1] | (lvl ? 32'h40 : 32'h80);
      repeat (2) @(posedge clk);
   endtask : ret

   task automatic quiet();
      int e0;
      e0 = entries;
      repeat (12) @(negedge clk);
      chk(32'(entries), 32'(e0));
   endtask : quiet

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      wr(8'h18, 32'h0000_0001);
      for (int a = 0; a < 7; a++) rdm(8'(a * 4 % 20 + (a / 5) * 24));
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr_next(rnd);
         wr(OFS_ENABLES, {16'h0000, rnd});
         wr(OFS_PRIORITIES, {16'h0000, ~rnd});
         pulse(lfsr_next(rnd));
         rdm(OFS_FLAGS);
         rdm(OFS_ENABLES);
         rdm(OFS_PRIORITIES);
         wr(OFS_FLAGS, 32'h0);
      end
      wr(OFS_ENABLES, 32'h0104);
      wr(OFS_PRIORITIES, 32'h0);
      wr(OFS_IRQ_CTRL_A, 32'h80);
      pulse(16'h0100);
      quiet();
      pulse(16'h0004);
      entry(1'b0);
      chk(32'(cnt >= 3 && cnt <= 4), 32'h1);
      rdm(OFS_IRQ_CTRL_A);
      wr(OFS_FLAGS, 32'h0100);
      ret();
      rdm(OFS_IRQ_CTRL_A);
      wr(OFS_IRQ_CTRL_A, 32'hC0);
      entry(1'b0);
      wr(OFS_FLAGS, 32'h0);
      ret();
      rdm(OFS_IRQ_CTRL_A);
      wr(OFS_IRQ_CTRL_A, 32'h0);
      wr(OFS_RESET_CTRL, 32'h80);
      wr(OFS_PRIORITIES, 32'h0008);
      wr(OFS_ENABLES, 32'h000C);
      wr(OFS_IRQ_CTRL_A, 32'hC0);
      pulse(16'h0004);
      entry(1'b1);
      rdm(OFS_IRQ_CTRL_A);
      pulse(16'h0008);
      entry(1'b0);
      axi(1'b0, OFS_STATUS, 32'h0);
      chk(q & 32'hFFFF0003, {VEC_HIGH, 16'h0003});
      wr(OFS_FLAGS, 32'h0004);
      wr(OFS_IRQ_CTRL_A, 32'hC0);
      quiet();
      wr(OFS_FLAGS, 32'h0);
      ret();
      ret();
      rdm(OFS_IRQ_CTRL_A);
      wr(OFS_IRQ_CTRL_A, 32'h40);
      pulse(16'h000C);
      quiet();
      @(posedge clk);
      coreSleep <= 1'b1;
      @(negedge clk);
      chk_out();
      // reset again in mid-run: priority mode and enables must fall back
      @(posedge clk);
      coreSleep <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      m = '{0, 0, 0, 0, 32'hFFFF};
      rdm(OFS_RESET_CTRL);
      rdm(OFS_IRQ_CTRL_A);
      rdm(OFS_FLAGS);
      wrap_up();
   end
endmodule : test_two_level_priority_interrupt_ctrl
